// ### wdt_pkg.sv
// Package for the I/O port watchdog timer: port address, timing, states.
// Assumes a 10 MHz system clock and an 8-bit I/O data path.
package wdt_pkg;
    localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;
    localparam int CLK_HZ = 10000000;
    localparam int TIMEOUT_MS = 1600;
    localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int TOL_PCT = 30;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
    localparam int TIMEOUT_TICKS = TIMEOUT_CYCLES / TICK_CYCLES;
    localparam int RST_PULSE_US = 10;
    localparam int RST_PULSE_CYCLES = (CLK_HZ / 1000000) * RST_PULSE_US;
    localparam logic [7:0] DATA_ON = 8'h01;
    localparam logic [7:0] DATA_OFF = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'hff;
    typedef enum logic [1:0] {WDT_OFF, WDT_RUN, WDT_FIRE} wdt_state_e;
endpackage : wdt_pkg

// ### wdt_tick.sv
// Time base divider producing a one-cycle tick enable.
// Assumes one free-running system clock.
`timescale 1ns/1ps
module wdt_tick #(
    parameter int DIV = 10000
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Tick enable output.
    output logic tick
);
    logic [31:0] cnt_r;

    // Count cycles and pulse the tick at the end of each period.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_r == 32'(DIV - 1)) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule : wdt_tick

// ### io_port_watchdog_timer.sv
// Watchdog timer reached through one host I/O port.
// Assumes single-cycle I/O strobes synchronous to sys_clk.
`timescale 1ns/1ps
module io_port_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int TIMEOUT_N = TIMEOUT_TICKS,
    parameter int PULSE_N = RST_PULSE_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Host I/O port access.
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Expiry action select and outputs.
    input wire logic irq_mode,
    output logic cpu_rst,
    output logic wdt_irq,
    output logic wdt_enabled
);
    import wdt_pkg::*;

    wdt_state_e state_r;
    logic [31:0] ticks_r;
    logic [31:0] pulse_r;
    logic tick;
    logic hit;
    logic refresh;
    logic stop;
    logic expire;

    // Free-running time base.
    wdt_tick #(.DIV(TICK_DIV)) u_tick (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    // Port decode; a one write or any read arms, a zero write stops.
    assign hit = (io_addr == WDT_PORT_ADDR);
    assign refresh = hit && ((io_wr && io_wdata == DATA_ON) || io_rd);
    assign stop = hit && io_wr && io_wdata == DATA_OFF;
    // Expiry sits exactly at the nominal count, well inside the spread
    // that the tolerance allows, so software margins stay on the host side.
    assign expire = (state_r == WDT_RUN) && tick &&
                    (ticks_r == 32'(TIMEOUT_N - 1));

    // State sequence of the watchdog.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= WDT_RUN;
        end else begin
            unique case (state_r)
                WDT_OFF: begin
                    if (refresh) begin
                        state_r <= WDT_RUN;
                    end
                end
                WDT_RUN: begin
                    if (stop) begin
                        state_r <= WDT_OFF;
                    end else if (refresh) begin
                        state_r <= WDT_RUN;
                    end else if (expire) begin
                        state_r <= WDT_FIRE;
                    end
                end
                WDT_FIRE: begin
                    if (pulse_r == 32'(PULSE_N - 1)) begin
                        state_r <= WDT_RUN;
                    end
                end
            endcase
        end
    end

    // Timeout counter; restarted by a refresh or any state change.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ticks_r <= 32'h0000_0000;
        end else if (state_r != WDT_RUN || refresh) begin
            ticks_r <= 32'h0000_0000;
        end else if (tick) begin
            ticks_r <= ticks_r + 32'h0000_0001;
        end
    end

    // Length of the expiry pulse.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_r <= 32'h0000_0000;
        end else if (state_r == WDT_FIRE) begin
            pulse_r <= pulse_r + 32'h0000_0001;
        end else begin
            pulse_r <= 32'h0000_0000;
        end
    end

    // Expiry action routed to reset or interrupt, from flip-flops.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_rst <= 1'b0;
            wdt_irq <= 1'b0;
        end else begin
            cpu_rst <= (state_r == WDT_FIRE) && !irq_mode;
            wdt_irq <= (state_r == WDT_FIRE) && irq_mode;
        end
    end

    // Read data shows the enable state in bit zero.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            io_rdata <= 8'h00;
        end else if (hit && io_rd) begin
            io_rdata <= {7'h00, state_r != WDT_OFF};
        end
    end

    assign wdt_enabled = (state_r != WDT_OFF);

    // Reset releases the block into the enabled state.
    property p_reset_on;
        @(posedge sys_clk) $fell(sys_rst) |-> state_r == WDT_RUN;
    endproperty
    a_reset_on: assert property (p_reset_on)
        else $error("not enabled after reset");

    property p_write_one;
        @(posedge sys_clk) disable iff (sys_rst)
        (hit && io_wr && io_wdata == DATA_ON && state_r != WDT_FIRE)
        |=> state_r == WDT_RUN && ticks_r == 32'h0000_0000;
    endproperty
    a_write_one: assert property (p_write_one)
        else $error("write one did not arm and restart");

    property p_read_arms;
        @(posedge sys_clk) disable iff (sys_rst)
        (hit && io_rd && !io_wr && state_r == WDT_OFF) |=> state_r == WDT_RUN;
    endproperty
    a_read_arms: assert property (p_read_arms)
        else $error("read did not arm");

    property p_expire;
        @(posedge sys_clk) disable iff (sys_rst)
        (expire && !refresh && !stop) |=> state_r == WDT_FIRE;
    endproperty
    a_expire: assert property (p_expire)
        else $error("timeout did not expire");

    property p_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        (stop && state_r != WDT_FIRE) |=> state_r == WDT_OFF;
    endproperty
    a_stop: assert property (p_stop)
        else $error("write zero did not stop");

    property p_off_quiet;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == WDT_OFF) |=> state_r != WDT_FIRE;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("expiry while disabled");

    property p_action;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(state_r == WDT_FIRE) |=> (cpu_rst || wdt_irq);
    endproperty
    a_action: assert property (p_action)
        else $error("no expiry action");

    property p_pulse_end;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == WDT_FIRE && pulse_r == 32'(PULSE_N - 1))
        |=> state_r == WDT_RUN ##1 !cpu_rst;
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("reset pulse did not end");

    // Read data reports the enable state seen at the read edge.
    property p_rdata;
        @(posedge sys_clk) disable iff (sys_rst)
        (hit && io_rd) |=> io_rdata == {7'h00, $past(wdt_enabled)};
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data does not show the enable state");

    // In reset mode the expiry drives only the CPU reset line.
    property p_rst_action;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == WDT_FIRE && !irq_mode) |=> cpu_rst && !wdt_irq;
    endproperty
    a_rst_action: assert property (p_rst_action)
        else $error("expiry did not drive the CPU reset");

    // In interrupt mode the expiry drives only the interrupt line.
    property p_irq_action;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == WDT_FIRE && irq_mode) |=> wdt_irq && !cpu_rst;
    endproperty
    a_irq_action: assert property (p_irq_action)
        else $error("expiry did not drive the interrupt");

    // Expiry only follows the full nominal count of ticks.
    property p_full_count;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(state_r == WDT_FIRE) |-> $past(ticks_r) == 32'(TIMEOUT_N - 1);
    endproperty
    a_full_count: assert property (p_full_count)
        else $error("expiry before the nominal count");

    // The expiry state never outlasts the set pulse length.
    property p_pulse_bound;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == WDT_FIRE) |-> pulse_r < 32'(PULSE_N);
    endproperty
    a_pulse_bound: assert property (p_pulse_bound)
        else $error("reset pulse too long");
endmodule : io_port_watchdog_timer

// ### wdt_host.sv
// Host processor model that drives the watchdog I/O port.
// Assumes the bench calls its tasks; all drives land at falling edges.
`timescale 1ns/1ps
module wdt_host (
    // Clock.
    input wire logic sys_clk,
    // Host I/O port drive.
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    import wdt_pkg::*;

    // Idle bus shows inverted values so nothing stale looks valid.
    initial begin
        io_addr = ~WDT_PORT_ADDR;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h5a;
    end

    // One single-cycle access to the port, then the bus is released.
    task automatic access(input logic wr, input logic [7:0] d);
        @(negedge sys_clk);
        io_addr = WDT_PORT_ADDR;
        io_wr = wr;
        io_rd = !wr;
        io_wdata = d;
        @(negedge sys_clk);
        io_addr = ~WDT_PORT_ADDR;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = ~d;
    endtask : access

    // Refreshes spaced well inside the shortest timeout.
    task automatic refresh(input int n, input int gap);
        repeat (n) begin
            access(1'b1, DATA_ON);
            repeat (gap) @(negedge sys_clk);
        end
    endtask : refresh
endmodule : wdt_host

// ### io_port_watchdog_timer_bench.sv
// Self-checking bench for the I/O port watchdog timer.
// Assumes short sim parameters: 4-cycle tick, 5 ticks, 3-cycle pulse.
`timescale 1ns/1ps
module io_port_watchdog_timer_bench;
    import wdt_pkg::*;
    localparam int SIM_DIV = 4;
    localparam int SIM_TICKS = 5;
    localparam int SIM_PULSE = 3;
    // Nominal timeout in cycles and the tolerance band around it.
    localparam int NOM_CYC = SIM_DIV * SIM_TICKS;
    localparam int LO_CYC = NOM_CYC * (100 - TOL_PCT) / 100;
    localparam int HI_CYC = NOM_CYC * (100 + TOL_PCT) / 100;
    localparam int CYC_LIMIT = 2000;
    logic sys_clk = 1'b0, sys_rst = 1'b1, irq_mode = 1'b0;
    logic [15:0] io_addr;
    logic io_wr, io_rd, cpu_rst, wdt_irq, wdt_enabled;
    logic [7:0] io_wdata, io_rdata;
    int err_total = 0, checked = 0, cyc = 0, lat, wid;

    // Clock at 10 MHz.
    always #50 sys_clk = ~sys_clk;

    // Host model and the block under test.
    wdt_host host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata));
    io_port_watchdog_timer #(.TICK_DIV(SIM_DIV), .TIMEOUT_N(SIM_TICKS),
        .PULSE_N(SIM_PULSE)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .irq_mode(irq_mode), .cpu_rst(cpu_rst),
        .wdt_irq(wdt_irq), .wdt_enabled(wdt_enabled));

    // Compares one value and counts the outcome.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Measures delay to the expiry pulse and its width, other output idle.
    task automatic expiry(input logic sel, input int start);
        lat = start;
        wid = 0;
        while ((sel ? wdt_irq : cpu_rst) !== 1'b1 && lat < start + 60) begin
            @(negedge sys_clk);
            lat++;
        end
        while ((sel ? wdt_irq : cpu_rst) === 1'b1 && wid < 20) begin
            chk(sel ? cpu_rst : wdt_irq, 8'h00);
            @(negedge sys_clk);
            wid++;
        end
    endtask : expiry

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // Cuts a hang short.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            err_total++;
            test_done;
        end
    end

    // After reset the timer runs and expires with no host access at all.
    task automatic test_reset;
        chk({7'h00, wdt_enabled}, 8'h01);
        chk({6'h00, cpu_rst, wdt_irq}, 8'h00);
        expiry(1'b0, 0);
        chk({7'h00, lat >= LO_CYC && lat <= HI_CYC}, 8'h01);
        chk(8'(wid), 8'(SIM_PULSE));
        $display("test reset done");
    endtask : test_reset

    // A zero write stops the timer; other data and idle time change nothing.
    task automatic test_stop;
        host.access(1'b1, DATA_OFF);
        chk({7'h00, wdt_enabled}, 8'h00);
        host.access(1'b1, 8'h7e);
        chk({7'h00, wdt_enabled}, 8'h00);
        repeat (60) @(negedge sys_clk);
        chk({6'h00, cpu_rst, wdt_irq}, 8'h00);
        $display("test stop done");
    endtask : test_stop

    // Reads arm the timer and report the enable state at the read edge.
    task automatic test_read;
        host.access(1'b0, 8'h00);
        chk(io_rdata, 8'h00);
        chk({7'h00, wdt_enabled}, 8'h01);
        host.access(1'b0, 8'h00);
        chk(io_rdata, 8'h01);
        $display("test read done");
    endtask : test_read

    // A one write restarts a stopped timer, and steady refreshes hold it.
    task automatic test_refresh;
        host.access(1'b1, DATA_OFF);
        host.access(1'b1, DATA_ON);
        chk({7'h00, wdt_enabled}, 8'h01);
        host.refresh(6, 9);
        chk({6'h00, cpu_rst, wdt_irq}, 8'h00);
        $display("test refresh done");
    endtask : test_refresh

    // Without refresh the CPU reset pulses once, then the timer runs on.
    // The count starts at the nine idle cycles since the last refresh.
    task automatic test_reset_pulse;
        expiry(1'b0, 9);
        chk({7'h00, lat >= LO_CYC && lat <= HI_CYC}, 8'h01);
        chk(8'(wid), 8'(SIM_PULSE));
        chk({7'h00, wdt_enabled}, 8'h01);
        $display("test reset pulse done");
    endtask : test_reset_pulse

    // In interrupt mode the same expiry pulses the interrupt line instead.
    task automatic test_irq;
        irq_mode = 1'b1;
        host.access(1'b1, DATA_ON);
        expiry(1'b1, 0);
        chk({7'h00, lat >= LO_CYC && lat <= HI_CYC}, 8'h01);
        chk(8'(wid), 8'(SIM_PULSE));
        $display("test irq done");
    endtask : test_irq

    // A system reset in mid-run brings a stopped timer back enabled.
    task automatic test_rerun;
        host.access(1'b1, DATA_OFF);
        chk({7'h00, wdt_enabled}, 8'h00);
        sys_rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk({6'h00, cpu_rst, wdt_irq}, 8'h00);
        sys_rst = 1'b0;
        chk({7'h00, wdt_enabled}, 8'h01);
        expiry(1'b1, 0);
        chk({7'h00, lat >= LO_CYC && lat <= HI_CYC}, 8'h01);
        $display("test rerun done");
    endtask : test_rerun

    // Main sequence of scenarios.
    initial begin
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        test_reset;
        test_stop;
        test_read;
        test_refresh;
        test_reset_pulse;
        test_irq;
        test_rerun;
        test_done;
    end
endmodule : io_port_watchdog_timer_bench
